//--- rtl/ssdfm_pkg.sv
// Constants, pin indices and types of the safety switch diagnostic block.
// Assumes a single 25 MHz clock; shared by the top and the flash generator.
package ssdfm_pkg;
    // Clock and time base
    localparam int CLK_HZ          = 25000000;
    localparam int TICK_MS         = 1;
    localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int WARN_DELAY_MIN  = 30;
    localparam int WARN_DELAY_MS   = WARN_DELAY_MIN * 60 * 1000;
    localparam int COMM_TIMEOUT_MS = 100;
    // Flash code timing in ms ticks
    localparam int FLASH_ON_MS     = 250;
    localparam int FLASH_OFF_MS    = 250;
    localparam int FLASH_PAUSE_MS  = 1500;
    localparam int BLINK_HALF_MS   = 250;
    localparam int CHAIN_MAX       = 31;

    // Synchronised pin indices
    localparam int PIN_GUARD    = 0;
    localparam int PIN_LOCKED   = 1;
    localparam int PIN_ACT      = 2;
    localparam int PIN_INA      = 3;
    localparam int PIN_INB      = 4;
    localparam int PIN_CODED    = 5;
    localparam int PIN_DRVA     = 6;
    localparam int PIN_DRVB     = 7;
    localparam int PIN_XWIRE    = 8;
    localparam int PIN_HOT      = 9;
    localparam int PIN_BADACT   = 10;
    localparam int PIN_ROTARY   = 11;
    localparam int PIN_INTERNAL = 12;
    localparam int PIN_TEACH    = 13;
    localparam int PIN_RELBLK   = 14;
    localparam int N_PIN        = 15;

    // Byte field positions
    localparam int RSP_ENABLED  = 0;
    localparam int RSP_ACTUATOR = 1;
    localparam int RSP_INPUTS   = 4;
    localparam int RSP_CODED    = 5;
    localparam int RSP_WARNING  = 6;
    localparam int RSP_FAILURE  = 7;
    localparam int DET_DRVA     = 0;
    localparam int DET_DRVB     = 1;
    localparam int DET_XWIRE    = 2;
    localparam int DET_HOT      = 3;
    localparam int DET_BADACT   = 4;
    localparam int DET_INTERNAL = 5;
    localparam int DET_COMM     = 6;
    localparam int DET_ROTARY   = 7;
    localparam int REQ_ERRRESET = 7;

    // Reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // Flash generator phases
    typedef enum logic [1:0] {
        FL_IDLE  = 2'b00,
        FL_ON    = 2'b01,
        FL_OFF   = 2'b10,
        FL_PAUSE = 2'b11
    } ssdfm_flash_t;
endpackage

//--- rtl/ssdfm_flash.sv
// Red indicator flash code generator: N pulses, then a dark pause.
// Assumes a one-cycle millisecond enable from the top's divider.
`timescale 1ns/1ps
module ssdfm_flash import ssdfm_pkg::*; (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    // Time base and code
    input  wire logic       tickMs,
    input  wire logic [2:0] pulses,
    // Indicator drive
    output logic            ledOn
);
    ssdfm_flash_t state_q;
    logic [15:0]  msCnt_q;
    logic [2:0]   pulseCnt_q;

    // End of current phase
    wire phaseDone = tickMs && (
        (state_q == FL_ON    && msCnt_q == 16'(FLASH_ON_MS - 1)) ||
        (state_q == FL_OFF   && msCnt_q == 16'(FLASH_OFF_MS - 1)) ||
        (state_q == FL_PAUSE && msCnt_q == 16'(FLASH_PAUSE_MS - 1)));
    wire lastPulse = (pulseCnt_q + 3'h1) >= pulses;

    // Phase sequence, repeated while a code is requested
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q    <= FL_IDLE;
            msCnt_q    <= 16'h0000;
            pulseCnt_q <= 3'h0;
        end else if (pulses == 3'h0) begin
            state_q    <= FL_IDLE;
            msCnt_q    <= 16'h0000;
            pulseCnt_q <= 3'h0;
        end else begin
            if (tickMs) msCnt_q <= phaseDone ? 16'h0000 : msCnt_q + 16'h0001;
            unique case (state_q)
                FL_IDLE: begin
                    state_q <= FL_ON;
                end
                FL_ON: begin
                    if (phaseDone) state_q <= lastPulse ? FL_PAUSE : FL_OFF;
                end
                FL_OFF: begin
                    if (phaseDone) begin
                        state_q    <= FL_ON;
                        pulseCnt_q <= pulseCnt_q + 3'h1;
                    end
                end
                FL_PAUSE: begin
                    if (phaseDone) begin
                        state_q    <= FL_ON;
                        pulseCnt_q <= 3'h0;
                    end
                end
            endcase
        end
    end

    // Lit only in the on phase
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) ledOn <= 1'b0;
        else       ledOn <= (state_q == FL_ON) && (pulses != 3'h0);
    end
endmodule // ssdfm_flash

//--- rtl/ssdfm_top.sv
// Diagnostic and fault manager of a safety interlock switch: indicators,
// safety drives, combined diagnostic output and the per-switch byte exchange.
// Assumes sensing pins are asynchronous and the request strobe is on clock.
//
// How it works
// - Green lit when powered and ready; red lit on error or warning.
// - Warnings flash 1..4 pulses for drive A, drive B, cross-wire, overtemperature.
// - Bad actuator flashes 5, rotary handle 6; both switch off at once.
// - Internal failure holds red steady and outputs off while it persists.
// - Cross-wire, overtemperature and drive faults switch off only after delay.
// - Conventional variant clears failures other than drive A/B and cross-wire after cause gone plus guard open-close.
// - Warning keeps outputs on, switches off after thirty minutes.
// - A warning clears itself once its cause is gone.
// - Diagnostic output high only if closed, locked and no warning.
// - Teach-in and release block drive their own indicator patterns, outputs low.
// - Serial chain carries diagnostics; at most 31 switches before gateway.
// - One request byte in, one response byte out per switch.
// - Lost gateway traffic never switches the safety outputs on; they can still switch off.
// - Serial failure clears after cause gone and reset bit falls or guard opens.
// - Failures of the safety drives stay latched until the next release.
// - Response bits: enabled, actuator, inputs, coding, warning, failure.
// - Detail bytes name drive A/B, cross-wire, heat, actuator, internal, comm, rotary.
// - Detail bytes are offered whenever a failure or warning is flagged.
// - A one in any byte means the condition is present.
`timescale 1ns/1ps
module ssdfm_top import ssdfm_pkg::*; #(
    parameter int TICK_CYC  = TICK_CYCLES,
    parameter int WARN_MS   = WARN_DELAY_MS
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    // Variant straps
    input  wire logic       serialVariant,
    input  wire logic       individual_coding_variant,
    input  wire logic       reteachable_coding_variant,
    // Sensing pins
    input  wire logic       guardClosed,
    input  wire logic       interlockLocked,
    input  wire logic       actuatorPresent,
    input  wire logic       safety_input_a,
    input  wire logic       safety_input_b,
    input  wire logic       codingValid,
    input  wire logic       driveAFault,
    input  wire logic       driveBFault,
    input  wire logic       crossWireFault,
    input  wire logic       overTempFault,
    input  wire logic       badActuatorFault,
    input  wire logic       rotaryFault,
    input  wire logic       internalFault,
    input  wire logic       teachActive,
    input  wire logic       releaseBlock,
    // Gateway request side
    input  wire logic       reqStrobe,
    input  wire logic [7:0] host_request_byte,
    // Gateway answer side
    output logic [7:0]      status_response_byte,
    output logic [7:0]      warning_detail_byte,
    output logic [7:0]      failure_detail_byte,
    // Safety and diagnostic outputs
    output logic            safety_drive_a,
    output logic            safety_drive_b,
    output logic            diagOut,
    // Indicators
    output logic            ledGreen,
    output logic            ledRed,
    output logic            ledYellow
);
    // Pin synchronisers: three stages, change taken when stages two and three agree
    wire  [N_PIN-1:0] pinRaw = {releaseBlock, teachActive, internalFault, rotaryFault,
                                badActuatorFault, overTempFault, crossWireFault,
                                driveBFault, driveAFault, codingValid, safety_input_b,
                                safety_input_a, actuatorPresent, interlockLocked,
                                guardClosed};
    logic [N_PIN-1:0] pin_q;
    genvar gi;
    generate
        for (gi = 0; gi < N_PIN; gi++) begin : gSync
            logic s1_q, s2_q, s3_q;
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    s1_q        <= 1'b0;
                    s2_q        <= 1'b0;
                    s3_q        <= 1'b0;
                    pin_q[gi]   <= 1'b0;
                end else begin
                    s1_q <= pinRaw[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) pin_q[gi] <= s3_q;
                end
            end
        end
    endgenerate

    // Straps caught after reset release
    logic serial_q, teachVar_q, reteachVar_q, strapDone_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            serial_q     <= 1'b0;
            teachVar_q   <= 1'b0;
            reteachVar_q <= 1'b0;
            strapDone_q  <= 1'b0;
        end else if (!strapDone_q) begin
            serial_q     <= serialVariant;
            teachVar_q   <= individual_coding_variant | reteachable_coding_variant;
            reteachVar_q <= reteachable_coding_variant;
            strapDone_q  <= 1'b1;
        end
    end

    // Named pin levels
    wire guardQ    = pin_q[PIN_GUARD];
    wire lockedQ   = pin_q[PIN_LOCKED];
    wire inputsQ   = pin_q[PIN_INA] & pin_q[PIN_INB];
    wire teachQ    = teachVar_q & pin_q[PIN_TEACH];
    wire relBlkQ   = reteachVar_q & pin_q[PIN_RELBLK];
    wire codedQ    = pin_q[PIN_CODED];
    wire [3:0] warnCause = {pin_q[PIN_HOT], pin_q[PIN_XWIRE],
                            pin_q[PIN_DRVB], pin_q[PIN_DRVA]};

    // Millisecond enable from the clock divider
    logic [31:0] divCnt_q;
    logic        tickMs_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            divCnt_q <= 32'h0000_0000;
            tickMs_q <= 1'b0;
        end else begin
            tickMs_q <= (divCnt_q == 32'(TICK_CYC - 1));
            divCnt_q <= (divCnt_q == 32'(TICK_CYC - 1)) ? 32'h0000_0000
                                                        : divCnt_q + 32'h0000_0001;
        end
    end

    // Warning delay timer, cleared whenever no warning cause remains
    logic [31:0] warnMs_q;
    wire warnLive    = |warnCause;
    wire warnExpired = warnLive && (warnMs_q == 32'(WARN_MS));
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)          warnMs_q <= 32'h0000_0000;
        else if (!warnLive) warnMs_q <= 32'h0000_0000;
        else if (tickMs_q && !warnExpired) warnMs_q <= warnMs_q + 32'h0000_0001;
    end

    // Gateway request register and traffic watchdog
    logic [7:0]  req_q;
    logic [15:0] commMs_q;
    logic        errResetFall_q;
    wire commLost = serial_q && (commMs_q == 16'(COMM_TIMEOUT_MS));
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            req_q          <= BYTE_RESET;
            commMs_q       <= 16'h0000;
            errResetFall_q <= 1'b0;
        end else begin
            errResetFall_q <= reqStrobe && req_q[REQ_ERRRESET]
                              && !host_request_byte[REQ_ERRRESET];
            if (reqStrobe) begin
                req_q    <= host_request_byte;
                commMs_q <= 16'h0000;
            end else if (tickMs_q && !commLost) begin
                commMs_q <= commMs_q + 16'h0001;
            end
        end
    end

    // Failure latch state, read by the guard tracking
    logic [7:0] fail_q;
    wire failAny = |fail_q;
    // Guard cycle tracking: open seen, then close
    logic guardPrev_q, openSeen_q;
    wire guardOpened = guardPrev_q & ~guardQ;
    wire guardReclosed = openSeen_q & guardQ;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            guardPrev_q <= 1'b0;
            openSeen_q  <= 1'b0;
        end else begin
            guardPrev_q <= guardQ;
            if (failAny)       openSeen_q <= openSeen_q | guardOpened;
            else               openSeen_q <= 1'b0;
        end
    end

    // Failure latch: immediate causes and expired warnings
    wire [7:0] failSet;
    assign failSet[3:0]          = warnExpired ? warnCause : 4'h0;
    assign failSet[DET_BADACT]   = pin_q[PIN_BADACT];
    assign failSet[DET_INTERNAL] = pin_q[PIN_INTERNAL];
    assign failSet[DET_COMM]     = 1'b0;
    assign failSet[DET_ROTARY]   = pin_q[PIN_ROTARY];
    // Clearing event per variant
    wire clrEvent = serial_q ? (errResetFall_q | guardOpened)
                             : guardReclosed;
    // Drive related failures wait for the next release (guard opening)
    wire [7:0] failClr;
    assign failClr[2:0] = {3{guardOpened}};
    assign failClr[7:3] = {5{clrEvent}};
    wire [7:0] failCause = {pin_q[PIN_ROTARY], 1'b0, pin_q[PIN_INTERNAL],
                            pin_q[PIN_BADACT], warnCause};
    // Set wins: a cause still present blocks its clear
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) fail_q <= BYTE_RESET;
        else       fail_q <= failSet | (fail_q & ~(failClr & ~failCause));
    end

    // Safety output enable; may fall but not rise while gateway traffic is lost
    wire enableCond = guardQ && lockedQ && inputsQ && codedQ && !failAny
                      && !(|failSet) && !teachQ && !relBlkQ;
    // While the link is lost enable may fall but never rise
    logic enable_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)         enable_q <= 1'b0;
        else if (commLost && !(|failSet) && !teachQ)
                           enable_q <= enable_q && enableCond;
        else               enable_q <= enableCond;
    end

    // Flash code selection: internal (no flash), actuator, rotary, then lowest warning or failure
    wire [3:0] driveCode = warnCause | fail_q[3:0];
    wire [2:0] pulseSel  = fail_q[DET_INTERNAL] ? 3'h0 :
                           fail_q[DET_BADACT]   ? 3'h5 :
                           fail_q[DET_ROTARY]   ? 3'h6 :
                           driveCode[0]         ? 3'h1 :
                           driveCode[1]         ? 3'h2 :
                           driveCode[2]         ? 3'h3 :
                           driveCode[3]         ? 3'h4 : 3'h0;
    logic flashLed;
    ssdfm_flash uFlash (
        .clock  (clock),
        .rstn   (rstn),
        .tickMs (tickMs_q),
        .pulses (pulseSel),
        .ledOn  (flashLed)
    );

    // Slow blink for teach-in and release block
    logic [15:0] blinkMs_q;
    logic        blink_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            blinkMs_q <= 16'h0000;
            blink_q   <= 1'b0;
        end else if (tickMs_q) begin
            if (blinkMs_q == 16'(BLINK_HALF_MS - 1)) begin
                blinkMs_q <= 16'h0000;
                blink_q   <= ~blink_q;
            end else begin
                blinkMs_q <= blinkMs_q + 16'h0001;
            end
        end
    end

    // Indicator levels
    wire redOn    = fail_q[DET_INTERNAL] | flashLed;
    wire greenOn  = relBlkQ ? blink_q : ~teachQ;
    wire redLed   = teachQ | (~relBlkQ & redOn);
    wire yellowOn = teachQ ? blink_q : (enable_q & ~relBlkQ);
    wire diagOn   = guardQ && lockedQ && !warnLive && !failAny
                    && !teachQ && !relBlkQ;

    // Response and detail bytes
    wire [7:0] rspByte;
    assign rspByte[RSP_ENABLED]  = enable_q;
    assign rspByte[RSP_ACTUATOR] = pin_q[PIN_ACT];
    assign rspByte[3:2]          = 2'h0;
    assign rspByte[RSP_INPUTS]   = inputsQ;
    assign rspByte[RSP_CODED]    = codedQ;
    assign rspByte[RSP_WARNING]  = warnLive | commLost;
    assign rspByte[RSP_FAILURE]  = failAny;
    wire [7:0] warnDet = {pin_q[PIN_ROTARY], commLost, pin_q[PIN_INTERNAL],
                          1'b0, warnCause};
    wire [7:0] failDet = {fail_q[7], 1'b0, fail_q[5:0]};

    // Registered outputs
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status_response_byte <= BYTE_RESET;
            warning_detail_byte  <= BYTE_RESET;
            failure_detail_byte  <= BYTE_RESET;
            safety_drive_a       <= 1'b0;
            safety_drive_b       <= 1'b0;
            diagOut              <= 1'b0;
            ledGreen             <= 1'b0;
            ledRed               <= 1'b0;
            ledYellow            <= 1'b0;
        end else begin
            status_response_byte <= rspByte;
            warning_detail_byte  <= rspByte[RSP_WARNING] ? warnDet
                                                         : BYTE_RESET;
            failure_detail_byte  <= failAny ? failDet : BYTE_RESET;
            safety_drive_a       <= enable_q;
            safety_drive_b       <= enable_q;
            diagOut              <= ~serial_q & diagOn;
            ledGreen             <= greenOn;
            ledRed               <= redLed;
            ledYellow            <= yellowOn;
        end
    end
endmodule // ssdfm_top

//--- sim/ssdfm_checker.sv
// Concurrent checks on the top's ports.
// Bound to the top by the bench.
`timescale 1ns/1ps
module ssdfm_checker import ssdfm_pkg::*; #(
    parameter int TICK_CYC = 10,
    parameter int WARN_MS  = 5
) (
    // Clock, reset and pins
    input wire logic       clock,
    input wire logic       rstn,
    input wire logic       guardClosed,
    input wire logic       driveAFault,
    input wire logic       driveBFault,
    input wire logic       crossWireFault,
    input wire logic       overTempFault,
    input wire logic       badActuatorFault,
    input wire logic       rotaryFault,
    input wire logic       internalFault,
    // Bytes and outputs
    input wire logic [7:0] status_response_byte,
    input wire logic [7:0] warning_detail_byte,
    input wire logic [7:0] failure_detail_byte,
    input wire logic       safety_drive_a,
    input wire logic       safety_drive_b,
    input wire logic       diagOut
);
    localparam int LIM = WARN_MS * TICK_CYC;
    // Fault groups
    wire warnPin = driveAFault | driveBFault | crossWireFault | overTempFault;
    wire stopPin = badActuatorFault | rotaryFault | internalFault;
    int  warnCnt;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // Cycles a drive warning has stood
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) warnCnt <= 0;
        else warnCnt <= (warning_detail_byte[3:0] != 4'h0) ? warnCnt + 1 : 0;
    end
    property p_drv; safety_drive_a == safety_drive_b; endproperty
    a_drv: assert property (p_drv) else $error("drives differ");
    property p_en; status_response_byte[0] == safety_drive_a; endproperty
    a_en: assert property (p_en) else $error("enable bit off");
    property p_diag; diagOut |-> !status_response_byte[6] && !status_response_byte[7]; endproperty
    a_diag: assert property (p_diag) else $error("diag high in fault");
    property p_guard; $fell(guardClosed) |-> ##[3:8] (!diagOut && !safety_drive_a); endproperty
    a_guard: assert property (p_guard) else $error("outputs high after opening");
    property p_warnDet; warning_detail_byte != 8'h00 |-> status_response_byte[6]; endproperty
    a_warnDet: assert property (p_warnDet) else $error("detail without flag");
    property p_failDet;
        failure_detail_byte != 8'h00 |-> status_response_byte[7] && !failure_detail_byte[6];
    endproperty
    a_failDet: assert property (p_failDet) else $error("failure detail bad");
    property p_stop; $rose(stopPin) |-> ##[1:8] !safety_drive_a; endproperty
    a_stop: assert property (p_stop) else $error("drives not cut at once");
    property p_warn; $rose(warnPin) |-> ##[3:8] status_response_byte[6]; endproperty
    a_warn: assert property (p_warn) else $error("warning not flagged");
    property p_hold;
        warnCnt > 1 && warnCnt < LIM - 12 && $past(safety_drive_a) |-> safety_drive_a;
    endproperty
    a_hold: assert property (p_hold) else $error("drives cut before delay");
    property p_exp; warnCnt == LIM + 15 |-> !safety_drive_a && status_response_byte[7]; endproperty
    a_exp: assert property (p_exp) else $error("drives on after delay");
endmodule // ssdfm_checker

//--- sim/ssdfm_gateway.sv
// Gateway model: request byte per strobe, detail fetch.
// Assumes the switch takes the byte on a strobed rising edge.
`timescale 1ns/1ps
module ssdfm_gateway #(
    parameter int GAP = 200
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    // Request out, answer in
    output logic            reqStrobe,
    output logic [7:0]      host_request_byte,
    input  wire logic [7:0] status_response_byte,
    input  wire logic [7:0] warning_detail_byte,
    input  wire logic [7:0] failure_detail_byte
);
    logic [7:0] req = 8'h00;  // Bit 7 asks for error reset
    logic       run = 1'b1;   // Low breaks the link
    logic [7:0] seenDetail = 8'h00; // Last detail byte
    int         gapCnt = 0;
    // Quiet start
    initial begin
        reqStrobe = 1'b0;
        host_request_byte = 8'h00;
    end
    // Byte lines show the inverse between strobes
    always @(negedge clock) begin
        gapCnt <= (!rstn || gapCnt == GAP - 1) ? 0 : gapCnt + 1;
        reqStrobe <= rstn && run && gapCnt == GAP - 1;
        host_request_byte <= (run && gapCnt == GAP - 1) ? req : ~req;
    end
    // Fetch the detail byte that the answer flags
    always @(posedge clock) begin
        if (status_response_byte[7]) seenDetail <= failure_detail_byte;
        else if (status_response_byte[6]) seenDetail <= warning_detail_byte;
    end
endmodule // ssdfm_gateway

//--- sim/test_safety_switch_diag_fault_manager.sv
// Bench of the fault manager: conventional, then serial.
// Gateway model and checker live in their own files.
`timescale 1ns/1ps
module test_safety_switch_diag_fault_manager import ssdfm_pkg::*;;
    localparam int TC = 10;
    localparam logic [29:0] NOLY = 30'h3ffffffc; // All but red and yellow
    localparam logic [29:0] STOP = {8'hbf, 8'h00, 8'hff, 6'h3c}; // Failure view
    localparam logic [29:0] IDLE = {8'h33, 16'h0, 6'b111101}; // Closed, all well
    localparam logic [29:0] SIDLE = {8'h33, 16'h0, 6'b110101}; // Same, serial
    logic clock = 1'b0, rstn = 1'b0, serialVariant = 1'b0, coding = 1'b1, redWas;
    logic [N_PIN-1:0] pin = '0;
    logic reqStrobe, safety_drive_a, safety_drive_b, diagOut, ledGreen, ledRed, ledYellow;
    logic [7:0] host_request_byte, status_response_byte, warning_detail_byte, failure_detail_byte;
    logic [59:0] q[$];
    logic [29:0] e;
    string nq[$];
    int fails = 0, checked = 0, n;
    int fb[3] = '{4, 7, 5};
    event look;
    wire [29:0] obs = {status_response_byte, warning_detail_byte, failure_detail_byte,
                       safety_drive_a, safety_drive_b, diagOut, ledGreen, ledRed, ledYellow};
    initial forever #20 clock = ~clock;
    ssdfm_top #(.TICK_CYC(TC), .WARN_MS(5)) uut (.*,
        .individual_coding_variant(coding), .reteachable_coding_variant(coding),
        .guardClosed(pin[PIN_GUARD]), .interlockLocked(pin[PIN_LOCKED]),
        .actuatorPresent(pin[PIN_ACT]), .safety_input_a(pin[PIN_INA]),
        .safety_input_b(pin[PIN_INB]), .codingValid(pin[PIN_CODED]),
        .driveAFault(pin[PIN_DRVA]), .driveBFault(pin[PIN_DRVB]),
        .crossWireFault(pin[PIN_XWIRE]), .overTempFault(pin[PIN_HOT]),
        .badActuatorFault(pin[PIN_BADACT]), .rotaryFault(pin[PIN_ROTARY]),
        .internalFault(pin[PIN_INTERNAL]), .teachActive(pin[PIN_TEACH]),
        .releaseBlock(pin[PIN_RELBLK]));
    ssdfm_gateway #(.GAP(200)) gw (.*);
    // Compare and count
    task automatic check(input string nm, input logic [29:0] seen, input logic [29:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Queue a masked expectation
    task automatic note(input string nm, input logic [29:0] m, input logic [29:0] x);
        q.push_back({m, x & m});
        nq.push_back(nm);
        ->look;
    endtask
    // Oldest note against the outputs
    always @(look) begin
        while (q.size() != 0) begin
            check(nq.pop_front(), obs & q[0][59:30], q[0][29:0]);
            void'(q.pop_front());
        end
    end
    task automatic wt(input int c);
        repeat (c) @(negedge clock);
    endtask
    task automatic results;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Reset with a variant strap
    task automatic boot(input logic ser);
        rstn = 1'b0;
        serialVariant = ser;
        wt(20);
        note("reset values", '1, '0);
        rstn = 1'b1;
        wt(12);
    endtask
    // Hang guard
    initial begin
        #3600000;
        fails++;
        results();
    end
    initial begin
        void'($urandom(32'hfa8b));
        boot(1'b0);
        pin[5:0] = 6'h3f;
        wt(12);
        note("guard closed", '1, IDLE);
        pin[PIN_LOCKED] = 1'b0;
        wt(12);
        note("unlocked", 30'h8, 30'h0);
        pin[PIN_LOCKED] = 1'b1;
        wt(12);
        $display("end of start-up test");
        // Warnings keep drives on and self-clear
        for (int i = 0; i < 4; i++) begin
            pin[PIN_DRVA + i] = 1'b1;
            wt(12);
            note("warning", NOLY, {8'h73, 8'h01 << i, 8'h00, 6'b110100});
            pin[PIN_DRVA + i] = 1'b0;
            wt(12);
            note("warning gone", '1, IDLE);
        end
        // Held drive B warning: switch-off, two pulses, latch
        pin[PIN_DRVB] = 1'b1;
        wt(80);
        note("warning expired", NOLY, {8'hf2, 8'h02, 8'h02, 6'b000100});
        n = 0;
        for (int c = 0; c < 4000 * TC && n < 1000 * TC; c++) begin
            @(negedge clock);
            n = ledRed ? 0 : n + 1;
        end
        n = 0;
        redWas = 1'b0;
        for (int c = 0; c < 1500 * TC; c++) begin
            @(negedge clock);
            if (ledRed && !redWas) n++;
            redWas = ledRed;
        end
        check("red pulses", 30'(n), 30'd2);
        pin[PIN_DRVB] = 1'b0;
        wt(12);
        note("drive failure latched", NOLY, {8'hb2, 8'h00, 8'h02, 6'b000100});
        pin[PIN_GUARD] = 1'b0;
        wt(12);
        note("guard open", '1, {8'h32, 16'h0, 6'b000100});
        pin[PIN_GUARD] = 1'b1;
        wt(12);
        note("closed again", '1, IDLE);
        $display("end of warning tests");
        // Immediate failures, cleared by a guard cycle
        for (int i = 0; i < 3; i++) begin
            e = {8'hb2, 8'h00, 8'h01 << fb[i], 6'b000100};
            pin[PIN_BADACT + i] = 1'b1;
            wt(12);
            note("failure", STOP, e);
            if (i == 2) repeat (3) begin
                wt(200 * TC);
                note("red steady", 30'h2, 30'h2);
            end
            pin[PIN_BADACT + i] = 1'b0;
            wt(12);
            note("failure held", STOP, e);
            pin[PIN_GUARD] = 1'b0;
            wt(12);
            pin[PIN_GUARD] = 1'b1;
            wt(12);
            note("failure cleared", '1, IDLE);
        end
        pin[PIN_TEACH] = 1'b1;
        wt(12);
        note("teach-in", 30'h3e, 30'h02);
        pin[PIN_TEACH] = 1'b0;
        pin[PIN_RELBLK] = 1'b1;
        wt(12);
        note("release block", 30'h3b, 30'h00);
        pin[PIN_RELBLK] = 1'b0;
        $display("end of failure and teach tests");
        // Serial: reset bit fall clears, link loss holds drives
        boot(1'b1);
        note("serial idle", '1, SIDLE);
        gw.req = {1'b1, 7'($urandom)};
        pin[PIN_BADACT] = 1'b1;
        wt(12);
        pin[PIN_BADACT] = 1'b0;
        wt(450);
        note("serial fail held", STOP, {8'hb2, 8'h00, 8'h10, 6'b000100});
        check("fetched detail", 30'(gw.seenDetail), 30'h10);
        gw.req = {1'b0, 7'($urandom)};
        wt(450);
        note("error reset", '1, SIDLE);
        gw.run = 1'b0;
        wt(1500);
        note("link lost", NOLY, {8'h73, 8'h40, 8'h00, 6'b110100});
        gw.run = 1'b1;
        wt(450);
        note("link back", '1, SIDLE);
        $display("end of serial tests");
        results();
    end
endmodule // test_safety_switch_diag_fault_manager
bind ssdfm_top ssdfm_checker #(.TICK_CYC(TICK_CYC), .WARN_MS(WARN_MS)) chk (.*);
